//--- core/fcc_current_ctrl.sv
// two-axis pi current controller with banded gain scheduling
//
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/10ps
// Notes on behaviour
// - selector 0 uses constant inductances
// - selector 99 takes iron inductance from nine-entry table
// - separate flux and torque current regulators
// - shared gain and integral time, bounded
// - zero gain or time disables path
// - flux reference steps, then ramps to magnetizing
// - integral action referenced to 2 kHz, rescaled
// - sample rate capped at 8 kHz
// - low current uses low gain
// - mid band uses base gain
// - high current uses high gain
// - default thresholds leave bands inactive
// - reluctance machine: q-axis own settings
// - q-axis cross coupling up to 300 %
// - each axis has three band gains
// - setup routine overwrites band settings
module fcc_current_ctrl (
	input  wire logic               core_clk,
	input  wire logic               rst_n,
	input  wire logic [4:0]         regAddr,
	input  wire logic [15:0]        regWrData,
	input  wire logic               regWr,
	input  wire logic               regRd,
	output logic      [15:0]        regRdData,
	input  wire logic signed [15:0] fluxCurrentMeas,
	input  wire logic signed [15:0] torqueCurrentMeas,
	input  wire logic signed [15:0] torqueCurrentRef,
	output logic signed [15:0]      fluxVoltageCmd,
	output logic signed [15:0]      torqueVoltageCmd,
	output logic      [15:0]        indIron,
	output logic      [15:0]        indAir,
	output logic                    sampleTick
);
	logic [15:0] ctrl, gain, tInt, gainLo, gainHi;
	logic [15:0] thrLo, thrBLo, thrBHi, thrHi;
	logic [15:0] qGain, qTInt, qGainLo, qGainHi, qThrLo, qThrHi;
	logic [15:0] xCouple, indIronC, indAirC, fluxCur, magCur, fluxTime;
	localparam int LUT_DEPTH_L = fcc_pkg::LUT_DEPTH;
	logic [15:0] lut [LUT_DEPTH_L];
	logic [16:0] smpCnt;
	logic [16:0] smpPeriod;
	logic [1:0]  gShift;
	logic [15:0] fluxTmr;
	logic signed [15:0] fluxRef;
	logic signed [31:0] integD, integQ;
	fcc_pkg::fcc_flux_type fluxState;
	logic [1:0]  bandD, bandQ;
	logic [15:0] selGainD, selGainQ, effTIntQ, magD, magQ;
	logic [7:0]  indSel;
	logic [3:0]  lutIdx;

	assign indSel = ctrl[fcc_pkg::CTRL_SEL_LO +: 8];

	// limit writes to the documented ranges rather than trusting software
	function automatic logic [15:0] clampv(input logic [15:0] v,
		input logic [15:0] mx);
		clampv = (v > mx) ? mx : v;
	endfunction

	// register writes; the setup routine rewrites bands through here
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ctrl     <= fcc_pkg::ZERO16;
			gain     <= fcc_pkg::GAIN_RST;
			tInt     <= fcc_pkg::TINT_RST;
			gainLo   <= fcc_pkg::ZERO16;
			gainHi   <= fcc_pkg::ZERO16;
			thrLo    <= fcc_pkg::ZERO16;
			thrBLo   <= fcc_pkg::THR_MAXR;
			thrBHi   <= fcc_pkg::ZERO16;
			thrHi    <= fcc_pkg::THR_MAXR;
			qGain    <= fcc_pkg::GAIN_RST;
			qTInt    <= fcc_pkg::TINT_RST;
			qGainLo  <= fcc_pkg::GAIN_RST;
			qGainHi  <= fcc_pkg::GAIN_RST;
			qThrLo   <= fcc_pkg::ZERO16;
			qThrHi   <= fcc_pkg::THR_MAXR;
			xCouple  <= fcc_pkg::ZERO16;
			indIronC <= fcc_pkg::ZERO16;
			indAirC  <= fcc_pkg::ZERO16;
			fluxCur  <= fcc_pkg::ZERO16;
			magCur   <= fcc_pkg::ZERO16;
			fluxTime <= fcc_pkg::ZERO16;
		end else if (regWr) begin
			case (regAddr)
				fcc_pkg::ADDR_CTRL:      ctrl     <= regWrData;
				fcc_pkg::ADDR_GAIN:
					gain <= clampv(regWrData, fcc_pkg::GAIN_MAX);
				fcc_pkg::ADDR_TINT:
					tInt <= clampv(regWrData, fcc_pkg::TINT_MAX);
				fcc_pkg::ADDR_GAIN_LO:   gainLo   <= regWrData;
				fcc_pkg::ADDR_GAIN_HI:   gainHi   <= regWrData;
				fcc_pkg::ADDR_THR_LO:    thrLo    <= regWrData;
				fcc_pkg::ADDR_THR_BLO:   thrBLo   <= regWrData;
				fcc_pkg::ADDR_THR_BHI:   thrBHi   <= regWrData;
				fcc_pkg::ADDR_THR_HI:    thrHi    <= regWrData;
				fcc_pkg::ADDR_QGAIN:
					qGain <= clampv(regWrData, fcc_pkg::GAIN_MAX);
				fcc_pkg::ADDR_QTINT:     qTInt    <= regWrData;
				fcc_pkg::ADDR_QGAIN_LO:
					qGainLo <= clampv(regWrData, fcc_pkg::GAIN_MAX);
				fcc_pkg::ADDR_QGAIN_HI:
					qGainHi <= clampv(regWrData, fcc_pkg::GAIN_MAX);
				fcc_pkg::ADDR_QTHR_LO:   qThrLo   <= regWrData;
				fcc_pkg::ADDR_QTHR_HI:   qThrHi   <= regWrData;
				fcc_pkg::ADDR_XCOUPLE:
					xCouple <= clampv(regWrData, fcc_pkg::XC_MAX);
				fcc_pkg::ADDR_IND_IRON:  indIronC <= regWrData;
				fcc_pkg::ADDR_IND_AIR:   indAirC  <= regWrData;
				fcc_pkg::ADDR_FLUX_CUR:  fluxCur  <= regWrData;
				fcc_pkg::ADDR_MAG_CUR:   magCur   <= regWrData;
				fcc_pkg::ADDR_FLUX_TIME: fluxTime <= regWrData;
				default: ;
			endcase
		end
	end

	// inductance table, one word per entry
	genvar gi;
	generate
		for (gi = 0; gi < LUT_DEPTH_L; gi++) begin : gLut
			always_ff @(posedge core_clk) begin
				if (!rst_n)
					lut[gi] <= fcc_pkg::ZERO16;
				else if (regWr && regAddr ==
					5'(fcc_pkg::ADDR_LUT_BASE + gi))
					lut[gi] <= regWrData;
			end
		end
	endgenerate

	// read mux, unmapped addresses read zero
	always_ff @(posedge core_clk) begin
		if (!rst_n)
			regRdData <= fcc_pkg::ZERO16;
		else if (regRd) begin
			case (regAddr)
				fcc_pkg::ADDR_CTRL:     regRdData <= ctrl;
				fcc_pkg::ADDR_GAIN:     regRdData <= gain;
				fcc_pkg::ADDR_TINT:     regRdData <= tInt;
				fcc_pkg::ADDR_QGAIN:    regRdData <= qGain;
				fcc_pkg::ADDR_XCOUPLE:  regRdData <= xCouple;
				fcc_pkg::ADDR_STATUS:
					regRdData <= {10'h000, bandQ, bandD, fluxState};
				default: begin
					if (regAddr >= fcc_pkg::ADDR_LUT_BASE &&
						regAddr < 5'(fcc_pkg::ADDR_LUT_BASE + LUT_DEPTH_L))
						regRdData <= lut[4'(regAddr - fcc_pkg::ADDR_LUT_BASE)];
					else
						regRdData <= fcc_pkg::ZERO16;
				end
			endcase
		end
	end

	// sample period and gain shift from switching frequency code
	always_comb begin
		case (ctrl[fcc_pkg::CTRL_FSW_LO +: 3])
			fcc_pkg::FSW_2K: begin
				smpPeriod = 17'(fcc_pkg::SMP_2K);
				gShift    = 2'(fcc_pkg::SHIFT_2K);
			end
			fcc_pkg::FSW_4K: begin
				smpPeriod = 17'(fcc_pkg::SMP_4K);
				gShift    = 2'(fcc_pkg::SHIFT_4K);
			end
			default: begin // 8, 12 and 16 kHz all sample at 8 kHz
				smpPeriod = 17'(fcc_pkg::SMP_8K);
				gShift    = 2'(fcc_pkg::SHIFT_8K);
			end
		endcase
	end

	// sample tick divider
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			smpCnt     <= 17'h00000;
			sampleTick <= 1'b0;
		end else if (smpCnt >= smpPeriod - 17'h00001) begin
			smpCnt     <= 17'h00000;
			sampleTick <= 1'b1;
		end else begin
			smpCnt     <= smpCnt + 17'h00001;
			sampleTick <= 1'b0;
		end
	end

	// band selection uses this sample's magnitudes combinationally
	assign magD = fluxCurrentMeas[15] ? 16'(-fluxCurrentMeas)
		: fluxCurrentMeas;
	assign magQ = torqueCurrentMeas[15] ? 16'(-torqueCurrentMeas)
		: torqueCurrentMeas;
	always_comb begin
		if (magD < thrLo) begin
			selGainD = gainLo;
			bandD    = 2'h0;
		end else if (magD > thrHi) begin
			selGainD = gainHi;
			bandD    = 2'h2;
		end else begin
			selGainD = gain;
			bandD    = 2'h1;
		end
		if (!ctrl[fcc_pkg::CTRL_SYNRM]) begin
			selGainQ = selGainD; // shared setting
			bandQ    = bandD;
			effTIntQ = tInt;
		end else if (magQ < qThrLo) begin
			selGainQ = qGainLo;
			bandQ    = 2'h0;
			effTIntQ = qTInt;
		end else if (magQ > qThrHi) begin
			selGainQ = qGainHi;
			bandQ    = 2'h2;
			effTIntQ = qTInt;
		end else begin
			selGainQ = qGain;
			bandQ    = 2'h1;
			effTIntQ = qTInt;
		end
	end

	// flux build-up: step to flux current, hold, then ramp to magnetizing
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			fluxState <= fcc_pkg::FCC_IDLE;
			fluxRef   <= 16'sh0000;
			fluxTmr   <= fcc_pkg::ZERO16;
		end else if (!ctrl[fcc_pkg::CTRL_RUN]) begin
			fluxState <= fcc_pkg::FCC_IDLE;
			fluxRef   <= 16'sh0000;
		end else if (sampleTick) begin
			case (fluxState)
				fcc_pkg::FCC_IDLE: begin
					fluxRef   <= fluxCur;
					fluxTmr   <= fluxTime;
					fluxState <= fcc_pkg::FCC_BUILD;
				end
				fcc_pkg::FCC_BUILD: begin
					if (fluxTmr == fcc_pkg::ZERO16)
						fluxState <= fcc_pkg::FCC_RAMP;
					else
						fluxTmr <= fluxTmr - 16'h0001;
				end
				fcc_pkg::FCC_RAMP: begin // one lsb per sample
					if (fluxRef > $signed(magCur))
						fluxRef <= fluxRef - 16'sh0001;
					else if (fluxRef < $signed(magCur))
						fluxRef <= fluxRef + 16'sh0001;
					else
						fluxState <= fcc_pkg::FCC_RUN;
				end
				fcc_pkg::FCC_RUN: fluxRef <= magCur;
				default: fluxState <= fcc_pkg::FCC_IDLE;
			endcase
		end
	end

	// pi step; integral increment scaled down as sampling speeds up so 2 kHz values hold
	function automatic logic signed [31:0] piStep(
		input logic signed [15:0] err, input logic [15:0] kp,
		input logic [15:0] ti, input logic [1:0] sh,
		input logic signed [31:0] integ, output logic signed [31:0] ni);
		logic signed [31:0] pPart;
		pPart = (kp == 16'h0000) ? 32'sh0
			: ($signed({16'h0000, kp}) * err) >>> 8;
		if (ti == 16'h0000)
			ni = 32'sh0;
		else
			ni = integ + ((pPart >>> sh) / $signed({16'h0000, ti}));
		piStep = pPart + ni;
	endfunction

	function automatic logic signed [15:0] sat16(input logic signed [31:0] v);
		if (v > 32'sh00007FFF)
			sat16 = 16'sh7FFF;
		else if (v < -32'sh00008000)
			sat16 = -16'sh8000;
		else
			sat16 = v[15:0];
	endfunction

	// both regulators update on the sample tick
	always_ff @(posedge core_clk) begin
		logic signed [31:0] outD, outQ, nD, nQ, xc;
		outD = 32'sh0;
		outQ = 32'sh0;
		nD = 32'sh0;
		nQ = 32'sh0;
		xc = 32'sh0;
		if (!rst_n || !ctrl[fcc_pkg::CTRL_RUN]) begin
			integD           <= 32'sh0;
			integQ           <= 32'sh0;
			fluxVoltageCmd   <= 16'sh0000;
			torqueVoltageCmd <= 16'sh0000;
		end else if (sampleTick) begin
			outD = piStep(16'(fluxRef - fluxCurrentMeas), selGainD, tInt,
				gShift, integD, nD);
			outQ = piStep(16'(torqueCurrentRef - torqueCurrentMeas),
				selGainQ, effTIntQ, gShift, integQ, nQ);
			if (ctrl[fcc_pkg::CTRL_SYNRM])
				xc = ($signed({16'h0000, xCouple}) * fluxCurrentMeas)
					/ 32'sd10000;
			integD           <= nD;
			integQ           <= nQ;
			fluxVoltageCmd   <= sat16(outD);
			torqueVoltageCmd <= sat16(outQ + xc);
		end
	end

	// inductance source: constants or table indexed by flux current
	assign lutIdx = (magD[15:12] > 4'h8) ? 4'h8 : magD[15:12];
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			indIron <= fcc_pkg::ZERO16;
			indAir  <= fcc_pkg::ZERO16;
		end else if (indSel == fcc_pkg::IND_LUT) begin
			indIron <= lut[lutIdx];
			indAir  <= indAirC;
		end else begin
			indIron <= indIronC;
			indAir  <= indAirC;
		end
	end
endmodule

//--- core/fcc_pkg.sv
// package with constants for the field-oriented current controller
package fcc_pkg;
	// register addresses (word index on the plain port)
	localparam logic [4:0] ADDR_CTRL      = 5'h00;
	localparam logic [4:0] ADDR_GAIN      = 5'h01;
	localparam logic [4:0] ADDR_TINT      = 5'h02;
	localparam logic [4:0] ADDR_GAIN_LO   = 5'h03;
	localparam logic [4:0] ADDR_GAIN_HI   = 5'h04;
	localparam logic [4:0] ADDR_THR_LO    = 5'h05;
	localparam logic [4:0] ADDR_THR_BLO   = 5'h06;
	localparam logic [4:0] ADDR_THR_BHI   = 5'h07;
	localparam logic [4:0] ADDR_THR_HI    = 5'h08;
	localparam logic [4:0] ADDR_QGAIN     = 5'h09;
	localparam logic [4:0] ADDR_QTINT     = 5'h0A;
	localparam logic [4:0] ADDR_QGAIN_LO  = 5'h0B;
	localparam logic [4:0] ADDR_QGAIN_HI  = 5'h0C;
	localparam logic [4:0] ADDR_QTHR_LO   = 5'h0D;
	localparam logic [4:0] ADDR_QTHR_HI   = 5'h0E;
	localparam logic [4:0] ADDR_XCOUPLE   = 5'h0F;
	localparam logic [4:0] ADDR_IND_IRON  = 5'h10;
	localparam logic [4:0] ADDR_IND_AIR   = 5'h11;
	localparam logic [4:0] ADDR_FLUX_CUR  = 5'h12;
	localparam logic [4:0] ADDR_MAG_CUR   = 5'h13;
	localparam logic [4:0] ADDR_FLUX_TIME = 5'h14;
	localparam logic [4:0] ADDR_STATUS    = 5'h15;
	localparam logic [4:0] ADDR_LUT_BASE  = 5'h16; // nine entries 16..1E
	localparam int         LUT_DEPTH      = 9;

	// ctrl register field positions
	localparam int CTRL_RUN    = 0;
	localparam int CTRL_SYNRM  = 1;
	localparam int CTRL_FSW_LO = 2; // 3 bit switching frequency code
	localparam int CTRL_SEL_LO = 8; // 8 bit inductance source selector

	// inductance source codes
	localparam logic [7:0] IND_CONST = 8'h00; // 0
	localparam logic [7:0] IND_LUT   = 8'h63; // 99

	// switching frequency codes
	localparam logic [2:0] FSW_2K  = 3'h0;
	localparam logic [2:0] FSW_4K  = 3'h1;
	localparam logic [2:0] FSW_8K  = 3'h2;
	localparam logic [2:0] FSW_12K = 3'h3;
	localparam logic [2:0] FSW_16K = 3'h4;

	// sample periods derived from the 200 MHz clock
	localparam int CLK_KHZ   = 200000;
	localparam int SMP_2K    = CLK_KHZ / 2;
	localparam int SMP_4K    = CLK_KHZ / 4;
	localparam int SMP_8K    = CLK_KHZ / 8;
	// gain rescale shift relative to the 2 kHz reference
	localparam int SHIFT_2K  = 0;
	localparam int SHIFT_4K  = 1;
	localparam int SHIFT_8K  = 2;

	// reset values; gains are Q8.8 (0.13 ~ 16'h0021), times in 10 us units
	localparam logic [15:0] GAIN_RST  = 16'h0021;
	localparam logic [15:0] GAIN_MAX  = 16'h0800; // 8.00
	localparam logic [15:0] TINT_RST  = 16'h03E8; // 10.00 ms
	localparam logic [15:0] TINT_MAX  = 16'h03E8;
	localparam logic [15:0] XC_MAX    = 16'h7530; // 300.00 % in 0.01 %
	localparam logic [15:0] THR_MAXR  = 16'hFFFF; // full scale current
	localparam logic [15:0] ZERO16    = 16'h0000;

	typedef enum logic [1:0] {
		FCC_IDLE  = 2'b00,
		FCC_BUILD = 2'b01,
		FCC_RAMP  = 2'b11,
		FCC_RUN   = 2'b10
	} fcc_flux_type;
endpackage

//--- tb/fcc_current_ctrl_chk.sv
// port checker for the current controller
`timescale 1ns/10ps
module fcc_current_ctrl_chk (
	input  wire logic               core_clk,
	input  wire logic               rst_n,
	input  wire logic [4:0]         regAddr,
	input  wire logic               regWr,
	input  wire logic               regRd,
	input  wire logic [15:0]        regRdData,
	input  wire logic signed [15:0] fluxVoltageCmd,
	input  wire logic               sampleTick
);
	// cycles since last sample; saturates so a slow rate never wraps
	logic [15:0] gap;
	logic        seen;
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			gap <= 16'h0000;
			seen <= 1'b0;
		end else begin
			gap <= sampleTick ? 16'h0000 : gap + {15'h0000, gap != 16'hFFFF};
			seen <= seen | sampleTick;
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	a_unmapped_rd_zero: assert property (regRd && regAddr > 5'h1E
		|=> regRdData == 16'h0000) else $error("unmapped read not zero");
	a_gain_rd_clamp: assert property (
		regRd && regAddr == fcc_pkg::ADDR_GAIN
		|=> regRdData <= fcc_pkg::GAIN_MAX) else $error("gain above limit");
	a_tint_rd_clamp: assert property (
		regRd && regAddr == fcc_pkg::ADDR_TINT
		|=> regRdData <= fcc_pkg::TINT_MAX) else $error("time above limit");
	a_qgain_rd_clamp: assert property (
		regRd && regAddr == fcc_pkg::ADDR_QGAIN
		|=> regRdData <= fcc_pkg::GAIN_MAX) else $error("q gain above limit");
	a_xc_rd_clamp: assert property (
		regRd && regAddr == fcc_pkg::ADDR_XCOUPLE
		|=> regRdData <= fcc_pkg::XC_MAX) else $error("coupling above limit");
	a_tick_one_cycle: assert property (sampleTick |=> !sampleTick)
		else $error("sample pulse too long");
	// the 8 kHz cap means no two samples closer than 25000 cycles
	a_tick_rate_cap: assert property (
		sampleTick && seen |-> gap >= 16'h61A7)
		else $error("sample rate above cap");
	a_cmd_stands: assert property (
		!$past(sampleTick) && !$past(regWr) && !$past(regWr, 2)
		|-> $stable(fluxVoltageCmd)) else $error("command moved off sample");
endmodule
bind fcc_current_ctrl fcc_current_ctrl_chk u_chk (.core_clk(core_clk),
	.rst_n(rst_n), .regAddr(regAddr), .regWr(regWr), .regRd(regRd),
	.regRdData(regRdData), .fluxVoltageCmd(fluxVoltageCmd),
	.sampleTick(sampleTick));

//--- tb/fcc_current_ctrl_tb_top.sv
// self-checking bench for the current controller
`timescale 1ns/10ps
module fcc_current_ctrl_tb_top;
	logic               core_clk = 1'b0;
	logic               rst_n = 1'b0;
	logic [4:0]         regAddr = 5'h00;
	logic [15:0]        regWrData = 16'h0000;
	logic               regWr = 1'b0;
	logic               regRd = 1'b0;
	logic signed [15:0] torqueCurrentRef = 16'sh0000;
	logic signed [15:0] bias = 16'sh0100;
	logic [15:0]        regRdData, indIron, indAir, v;
	logic signed [15:0] fluxCurrentMeas, torqueCurrentMeas;
	logic signed [15:0] fluxVoltageCmd, torqueVoltageCmd;
	logic               sampleTick;
	logic [1:0]         b0, b1, b2;
	int                 bad_count = 0;
	int                 cmp_count = 0;
	int                 regModel[32];
	longint             tk[$];

	always #2.5 core_clk = ~core_clk;

	fcc_current_ctrl u_fcc_current_ctrl (.core_clk(core_clk), .rst_n(rst_n),
		.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
		.regRd(regRd), .regRdData(regRdData),
		.fluxCurrentMeas(fluxCurrentMeas),
		.torqueCurrentMeas(torqueCurrentMeas),
		.torqueCurrentRef(torqueCurrentRef), .fluxVoltageCmd(fluxVoltageCmd),
		.torqueVoltageCmd(torqueVoltageCmd), .indIron(indIron),
		.indAir(indAir), .sampleTick(sampleTick));
	fcc_motor_model u_fcc_motor_model (.fluxVoltageCmd(fluxVoltageCmd),
		.torqueVoltageCmd(torqueVoltageCmd), .bias(bias),
		.fluxCurrentMeas(fluxCurrentMeas),
		.torqueCurrentMeas(torqueCurrentMeas));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// register model: gain, q gains, time and coupling saturate at their maxima
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge core_clk);
		regWr <= 1'b0;
		if (a inside {1, 9, 11, 12})
			regModel[a] = d > 16'h0800 ? 16'h0800 : d;
		else if (a == 2)
			regModel[a] = d > 16'h03E8 ? 16'h03E8 : d;
		else if (a == 15)
			regModel[a] = d > 16'h7530 ? 16'h7530 : d;
		else if (a != 21 && a < 31)
			regModel[a] = d;
	endtask
	task automatic rdv(input logic [4:0] a, output logic [15:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge core_clk);
		regRd <= 1'b0;
		#1 d = regRdData;
	endtask
	// only a few registers read back; the rest answer zero
	task automatic rdChk(input logic [4:0] a);
		rdv(a, v);
		chk(v, (a inside {0, 1, 2, 9, 15} || (a > 21 && a < 31)) ?
			regModel[a][15:0] : 16'h0000);
	endtask
	// bounded wait for a sample, then let the commands land
	task automatic waitTick();
		int n;
		n = 0;
		while (sampleTick !== 1'b1 && n < 30000) begin
			@(negedge core_clk);
			n++;
		end
		if (n >= 30000)
			bad_count++;
		tk.push_back($time);
		repeat (2) @(negedge core_clk);
	endtask
	task automatic results();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// watchdog sized for three 8 kHz samples plus margin, 90000 cycles
	initial begin
		#450000;
		bad_count++;
		results();
	end

	initial begin
		regModel = '{default: 0};
		regModel[1] = 16'h0021;
		regModel[2] = 16'h03E8;
		regModel[9] = 16'h0021;
		void'($urandom(60));
		repeat (12) @(posedge core_clk);
		rst_n <= 1'b1;
		for (int a = 0; a < 32; a++)
			if (a != 21) rdChk(a[4:0]);
		for (int i = 0; i < 24; i++) begin
			v = 16'($urandom);
			wr(i < 12 ? {2'b00, 3'(i % 4)} ^ 5'h01 : 5'(16 + i), v);
			rdChk(regAddr);
		end
		$display("register test done");
		// random writes left a low band threshold; restore the default
		wr(fcc_pkg::ADDR_THR_LO, 16'h0000);
		wr(fcc_pkg::ADDR_GAIN, 16'h0000);
		wr(fcc_pkg::ADDR_TINT, 16'h0000);
		wr(fcc_pkg::ADDR_IND_IRON, 16'h1234);
		wr(fcc_pkg::ADDR_IND_AIR, 16'h0567);
		wr(fcc_pkg::ADDR_CTRL, 16'h0011);
		rdChk(fcc_pkg::ADDR_CTRL);
		torqueCurrentRef <= 16'sh1000;
		waitTick();
		chk(fluxVoltageCmd, 16'h0000);
		chk(torqueVoltageCmd, 16'h0000);
		chk(indIron, 16'h1234);
		chk(indAir, 16'h0567);
		rdv(fcc_pkg::ADDR_STATUS, v);
		b0 = v[3:2];
		$display("zero gain test done");
		wr(fcc_pkg::ADDR_GAIN, 16'h0100);
		wr(fcc_pkg::ADDR_GAIN_LO, 16'h0100);
		wr(fcc_pkg::ADDR_THR_LO, 16'h7FFF);
		waitTick();
		chk({15'h0000, torqueVoltageCmd > 16'sh0000}, 16'h0001);
		chk({15'h0000, fluxVoltageCmd < 16'sh0000}, 16'h0001);
		chk(16'((tk[1] - tk[0]) / 5), 16'h61A8);
		rdv(fcc_pkg::ADDR_STATUS, v);
		b1 = v[3:2];
		chk({15'h0000, b1 != b0}, 16'h0001);
		$display("low band test done");
		wr(fcc_pkg::ADDR_THR_LO, 16'h0000);
		wr(fcc_pkg::ADDR_THR_HI, 16'h0000);
		// known high gain keeps the current off zero; table entry 0 is used
		wr(fcc_pkg::ADDR_GAIN_HI, 16'h0080);
		wr(fcc_pkg::ADDR_LUT_BASE, 16'h0ABC);
		wr(fcc_pkg::ADDR_CTRL, 16'h6311);
		waitTick();
		chk(indIron, regModel[22][15:0]);
		rdv(fcc_pkg::ADDR_STATUS, v);
		b2 = v[3:2];
		chk({15'h0000, b2 != b0 && b2 != b1}, 16'h0001);
		$display("high band test done");
		results();
	end
endmodule

//--- tb/fcc_motor_model.sv
// behavioural power stage and phase current sensing
`timescale 1ns/10ps
module fcc_motor_model (
	input  wire logic signed [15:0] fluxVoltageCmd,
	input  wire logic signed [15:0] torqueVoltageCmd,
	input  wire logic signed [15:0] bias,
	output logic signed [15:0]      fluxCurrentMeas,
	output logic signed [15:0]      torqueCurrentMeas
);
	// resistive load: small share of voltage on top of a set operating level
	assign fluxCurrentMeas = bias + (fluxVoltageCmd >>> 4);
	assign torqueCurrentMeas = bias + (torqueVoltageCmd >>> 4);
endmodule
